// File: rtl/dcsl_byte_sel.sv
// byte lane writer for a little-endian multi-byte register
// assumes the caller qualifies the write strobe with ownership
module dcsl_byte_sel #(
	parameter logic [11:0] BASE  = 12'h000,
	parameter int          BYTES = 8
) (
	// access
	input  wire logic [11:0]        addr_i,
	input  wire logic               wr_i,
	input  wire logic [7:0]         wdata_i,
	input  wire logic [BYTES*8-1:0] cur_i,
	// result
	output logic      [BYTES*8-1:0] next_o,
	output logic                    hit_o,
	output logic      [BYTES-1:0]   lane_o
);
	genvar g;
	generate
		for (g = 0; g < BYTES; g++)
		begin : g_lane
			// lowest address holds the least significant byte
			assign lane_o[g] = wr_i && (addr_i == BASE + 12'(g));
			assign next_o[g*8 +: 8] = lane_o[g] ? wdata_i : cur_i[g*8 +: 8];
		end
	endgenerate
	assign hit_o = |lane_o;
endmodule

// File: rtl/dcsl_pkg.sv
// package for the sync pulse / latch control register block
// assumes byte-wide register ports from both access sides
// What this block does
// - activation records start time plausibility in bit 2
// - bit 1 shows output b first pulse pending
// - bit 0 shows output a first pulse pending
// - ack mode: host read clears output a
// - ack mode: host read clears output b
// - start time write sets start, read gives next
// - start time writable only under network ownership
// - auto-activation extends lower-only write to 64 bits
// - read-only next output b pulse time
// - output a cycle time, zero means single shot
// - output b offset time after output a pulse
// - cycle time writes governed by ownership bit
// - latch a bit 1 negative edge single event
// - latch a bit 0 positive edge single event
// - latch b same bit layout as latch a
// - latch control writes governed by unit ownership
// - multi-byte registers little-endian byte addressed
// - pulse length zero selects acknowledge mode
// - sync ownership 0 network, 1 host
// - start time write auto-sets activation when enabled
// - latch ownership 0 network, 1 host, routes interrupt
package dcsl_pkg;
	localparam logic [11:0] ADDR_ACT_STATUS = 12'h984;
	localparam logic [11:0] ADDR_A_ACK      = 12'h98e;
	localparam logic [11:0] ADDR_B_ACK      = 12'h98f;
	localparam logic [11:0] ADDR_START      = 12'h990;
	localparam logic [11:0] ADDR_NEXT_B     = 12'h998;
	localparam logic [11:0] ADDR_A_CYCLE    = 12'h9a0;
	localparam logic [11:0] ADDR_B_CYCLE    = 12'h9a4;
	localparam logic [11:0] ADDR_LATCH_A    = 12'h9a8;
	localparam logic [11:0] ADDR_LATCH_B    = 12'h9a9;
	localparam int          ACT_PLAUS_BIT   = 2;
	localparam int          ACT_B_PEND_BIT  = 1;
	localparam int          ACT_A_PEND_BIT  = 0;
	localparam int          LATCH_NEG_BIT   = 1;
	localparam int          LATCH_POS_BIT   = 0;
	localparam logic [1:0]  LATCH_MASK      = 2'h3;
	localparam logic [31:0] NEAR_SHORT_NS   = 32'h7fffffff;
endpackage

// File: rtl/dcsl_regs.sv
// sync pulse generator control, status and latch mode registers
// assumes two byte ports (network side, host side) on ref_clk_i;
// system time comes from the local clock unit on the same clock
module dcsl_regs (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_n_i,
	// network side byte port
	input  wire logic [11:0] net_addr_i,
	input  wire logic        net_wr_i,
	input  wire logic        net_rd_i,
	input  wire logic [7:0]  net_wdata_i,
	input  wire logic        net_frame_end_i,
	output logic      [7:0]  net_rdata_o,
	// host process port
	input  wire logic [11:0] host_addr_i,
	input  wire logic        host_wr_i,
	input  wire logic        host_rd_i,
	input  wire logic [7:0]  host_wdata_i,
	output logic      [7:0]  host_rdata_o,
	// settings held by neighbouring registers
	input  wire logic        sync_own_host_i,
	input  wire logic        latch_a_own_host_i,
	input  wire logic        latch_b_own_host_i,
	input  wire logic        act_enable_i,
	input  wire logic        act_auto_i,
	input  wire logic        act_plaus_en_i,
	input  wire logic        act_near_long_i,
	input  wire logic        act_gen_a_i,
	input  wire logic        act_gen_b_i,
	input  wire logic [15:0] pulse_len_i,
	input  wire logic [63:0] sys_time_i,
	// outputs
	output logic             act_auto_set_o,
	output logic             sync_out_a_o,
	output logic             sync_out_b_o,
	output logic      [1:0]  latch_a_mode_o,
	output logic      [1:0]  latch_b_mode_o,
	output logic             latch_a_irq_host_o,
	output logic             latch_b_irq_host_o
);
	// register state
	logic [63:0] start_q,  start_d;
	logic [63:0] next_b_q, next_b_d;
	logic [31:0] cyc_a_q,  cyc_a_d;
	logic [31:0] cyc_b_q,  cyc_b_d;
	logic [1:0]  lat_a_q,  lat_a_d;
	logic [1:0]  lat_b_q,  lat_b_d;
	logic        pend_a_q, pend_b_q, plaus_q, act_q, b_due_q, done_q;
	logic        out_a_q,  out_b_q,  upper_wr_q, lower_wr_q, imm_q;

	// only the owning side may write a unit; start time is written by the network side only, under network ownership
	wire         sync_wr   = sync_own_host_i ? host_wr_i : net_wr_i;
	wire [11:0]  sync_addr = sync_own_host_i ? host_addr_i : net_addr_i;
	wire [7:0]   sync_data = sync_own_host_i ? host_wdata_i : net_wdata_i;
	wire         start_wr  = net_wr_i && !sync_own_host_i;
	wire         la_wr     = latch_a_own_host_i ? host_wr_i : net_wr_i;
	wire         lb_wr     = latch_b_own_host_i ? host_wr_i : net_wr_i;
	wire [11:0]  la_addr   = latch_a_own_host_i ? host_addr_i : net_addr_i;
	wire [11:0]  lb_addr   = latch_b_own_host_i ? host_addr_i : net_addr_i;
	wire [7:0]   la_data   = latch_a_own_host_i ? host_wdata_i : net_wdata_i;
	wire [7:0]   lb_data   = latch_b_own_host_i ? host_wdata_i : net_wdata_i;

	wire [63:0]  start_w;
	wire [31:0]  cyc_a_w, cyc_b_w;
	wire [7:0]   lat_a_w, lat_b_w;
	wire [7:0]   start_lane;
	wire         start_hit, cyc_a_hit, cyc_b_hit, lat_a_hit, lat_b_hit;

	dcsl_byte_sel #(.BASE(dcsl_pkg::ADDR_START), .BYTES(8)) u_start (
		.addr_i  (net_addr_i),
		.wr_i    (start_wr),
		.wdata_i (net_wdata_i),
		.cur_i   (start_q),
		.next_o  (start_w),
		.hit_o   (start_hit),
		.lane_o  (start_lane)
	);
	dcsl_byte_sel #(.BASE(dcsl_pkg::ADDR_A_CYCLE), .BYTES(4)) u_cyc_a (
		.addr_i  (sync_addr),
		.wr_i    (sync_wr),
		.wdata_i (sync_data),
		.cur_i   (cyc_a_q),
		.next_o  (cyc_a_w),
		.hit_o   (cyc_a_hit),
		.lane_o  ()
	);
	dcsl_byte_sel #(.BASE(dcsl_pkg::ADDR_B_CYCLE), .BYTES(4)) u_cyc_b (
		.addr_i  (sync_addr),
		.wr_i    (sync_wr),
		.wdata_i (sync_data),
		.cur_i   (cyc_b_q),
		.next_o  (cyc_b_w),
		.hit_o   (cyc_b_hit),
		.lane_o  ()
	);
	dcsl_byte_sel #(.BASE(dcsl_pkg::ADDR_LATCH_A), .BYTES(1)) u_lat_a (
		.addr_i  (la_addr),
		.wr_i    (la_wr),
		.wdata_i (la_data),
		.cur_i   ({6'h00, lat_a_q}),
		.next_o  (lat_a_w),
		.hit_o   (lat_a_hit),
		.lane_o  ()
	);
	dcsl_byte_sel #(.BASE(dcsl_pkg::ADDR_LATCH_B), .BYTES(1)) u_lat_b (
		.addr_i  (lb_addr),
		.wr_i    (lb_wr),
		.wdata_i (lb_data),
		.cur_i   ({6'h00, lat_b_q}),
		.next_o  (lat_b_w),
		.hit_o   (lat_b_hit),
		.lane_o  ()
	);

	// lower-only write within one frame: upper word tracks system time
	// a byte written in the frame-end cycle still counts for that frame
	wire        low_seen  = lower_wr_q || (|start_lane[3:0]);
	wire        high_seen = upper_wr_q || (|start_lane[7:4]);
	wire [63:0] start_ext = {sys_time_i[63:32], start_w[31:0]};
	wire        extend    = net_frame_end_i && act_auto_i && low_seen && !high_seen;

	// plausibility: start must lie within the near-future window
	wire [63:0] delta     = start_q - sys_time_i;
	wire        far_short = delta[63:31] != 33'h0;
	wire        far_long  = delta[63] || (delta[62:32] != 31'h0);
	wire        out_near  = act_near_long_i ? far_short : far_long;

	wire        act_rise  = act_enable_i && !act_q;
	wire        reached   = act_q && !done_q && ($signed(sys_time_i - start_q) >= 0);
	// an out-of-window start fires once only; plaus_q itself stays as status
	wire        fire_a    = reached || (act_q && !done_q && act_plaus_en_i && imm_q);
	wire        fire_b    = b_due_q && ($signed(sys_time_i - next_b_q) >= 0);
	wire        ack_mode  = pulse_len_i == 16'h0000;

	// host read of an ack status register drops its output
	wire        clr_a     = ack_mode && host_rd_i && host_addr_i == dcsl_pkg::ADDR_A_ACK;
	wire        clr_b     = ack_mode && host_rd_i && host_addr_i == dcsl_pkg::ADDR_B_ACK;

	always_comb
	begin
		start_d  = extend ? start_ext : start_w;
		next_b_d = next_b_q;
		if (fire_a)
		begin
			// cyclic mode moves the read-back time to the next pulse
			if (cyc_a_q != 32'h0)
				start_d = start_q + 64'(cyc_a_q);
			next_b_d = start_q + 64'(cyc_b_q);
		end
		cyc_a_d = cyc_a_w;
		cyc_b_d = cyc_b_w;
		lat_a_d = lat_a_w[1:0] & dcsl_pkg::LATCH_MASK;
		lat_b_d = lat_b_w[1:0] & dcsl_pkg::LATCH_MASK;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			start_q    <= 64'h0;
			next_b_q   <= 64'h0;
			cyc_a_q    <= 32'h0;
			cyc_b_q    <= 32'h0;
			lat_a_q    <= 2'h0;
			lat_b_q    <= 2'h0;
			upper_wr_q <= 1'b0;
			lower_wr_q <= 1'b0;
		end
		else
		begin
			start_q  <= start_d;
			next_b_q <= next_b_d;
			cyc_a_q  <= cyc_a_d;
			cyc_b_q  <= cyc_b_d;
			lat_a_q  <= lat_a_d;
			lat_b_q  <= lat_b_d;
			if (net_frame_end_i)
			begin
				upper_wr_q <= 1'b0;
				lower_wr_q <= 1'b0;
			end
			else
			begin
				upper_wr_q <= upper_wr_q || (|start_lane[7:4]);
				lower_wr_q <= lower_wr_q || (|start_lane[3:0]);
			end
		end
	end

	// activation and pulse state
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			act_q    <= 1'b0;
			done_q   <= 1'b0;
			pend_a_q <= 1'b0;
			pend_b_q <= 1'b0;
			plaus_q  <= 1'b0;
			imm_q    <= 1'b0;
			b_due_q  <= 1'b0;
			out_a_q  <= 1'b0;
			out_b_q  <= 1'b0;
		end
		else
		begin
			act_q <= act_enable_i;
			if (act_rise)
			begin
				done_q   <= 1'b0;
				imm_q    <= out_near;
				pend_a_q <= act_gen_a_i;
				pend_b_q <= act_gen_b_i;
				plaus_q  <= out_near;
			end
			else if (!act_enable_i)
			begin
				pend_a_q <= 1'b0;
				pend_b_q <= 1'b0;
				b_due_q  <= 1'b0;
				imm_q    <= 1'b0;
			end
			else
			begin
				if (fire_b)
				begin
					pend_b_q <= 1'b0;
					b_due_q  <= 1'b0;
				end
				// after output b, so a coinciding a pulse re-arms b
				if (fire_a)
				begin
					pend_a_q <= 1'b0;
					imm_q    <= 1'b0;
					b_due_q  <= act_gen_b_i;
					if (cyc_a_q == 32'h0)
						done_q <= 1'b1;
				end
			end
			// a new pulse wins over a clearing read in the same cycle
			if (fire_a && act_gen_a_i)
				out_a_q <= 1'b1;
			else if (clr_a || !ack_mode)
				out_a_q <= 1'b0;
			if (fire_b && act_gen_b_i)
				out_b_q <= 1'b1;
			else if (clr_b || !ack_mode)
				out_b_q <= 1'b0;
		end
	end

	assign act_auto_set_o     = act_auto_i && start_hit;
	assign sync_out_a_o       = out_a_q;
	assign sync_out_b_o       = out_b_q;
	assign latch_a_mode_o     = lat_a_q;
	assign latch_b_mode_o     = lat_b_q;
	assign latch_a_irq_host_o = latch_a_own_host_i;
	assign latch_b_irq_host_o = latch_b_own_host_i;

	// byte read mux shared by both ports
	function automatic logic [7:0] rd_byte(input logic [11:0] a);
		logic [11:0] o;
		o = a - dcsl_pkg::ADDR_START;
		rd_byte = 8'h00;
		if (a == dcsl_pkg::ADDR_ACT_STATUS)
			rd_byte = {5'h00, plaus_q, pend_b_q, pend_a_q};
		else if (a == dcsl_pkg::ADDR_A_ACK)
			rd_byte = {7'h00, out_a_q};
		else if (a == dcsl_pkg::ADDR_B_ACK)
			rd_byte = {7'h00, out_b_q};
		else if (o < 12'h008)
			rd_byte = start_q[o[2:0]*8 +: 8];
		else if (o < 12'h010)
			rd_byte = next_b_q[o[2:0]*8 +: 8];
		else if (o < 12'h014)
			rd_byte = cyc_a_q[o[1:0]*8 +: 8];
		else if (o < 12'h018)
			rd_byte = cyc_b_q[o[1:0]*8 +: 8];
		else if (a == dcsl_pkg::ADDR_LATCH_A)
			rd_byte = {6'h00, lat_a_q};
		else if (a == dcsl_pkg::ADDR_LATCH_B)
			rd_byte = {6'h00, lat_b_q};
	endfunction

	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			net_rdata_o  <= 8'h00;
			host_rdata_o <= 8'h00;
		end
		else
		begin
			if (net_rd_i)
				net_rdata_o <= rd_byte(net_addr_i);
			if (host_rd_i)
				host_rdata_o <= rd_byte(host_addr_i);
		end
	end
endmodule

// File: verification/dcsl_regs_props.sv
// port checks for the sync pulse and latch control registers
// bound into dcsl_regs, one clock domain, reset active low
module dcsl_regs_props (
	// clock and reset
	input wire logic        ref_clk_i,
	input wire logic        reset_n_i,
	// access ports
	input wire logic [11:0] net_addr_i,
	input wire logic        net_wr_i,
	input wire logic [7:0]  net_wdata_i,
	input wire logic [11:0] host_addr_i,
	input wire logic        host_wr_i,
	input wire logic        host_rd_i,
	input wire logic [7:0]  host_wdata_i,
	// settings
	input wire logic        sync_own_host_i,
	input wire logic        latch_a_own_host_i,
	input wire logic        latch_b_own_host_i,
	input wire logic        act_auto_i,
	input wire logic [15:0] pulse_len_i,
	// outputs
	input wire logic        act_auto_set_o,
	input wire logic        sync_out_a_o,
	input wire logic        sync_out_b_o,
	input wire logic [1:0]  latch_a_mode_o,
	input wire logic [1:0]  latch_b_mode_o,
	input wire logic        latch_a_irq_host_o,
	input wire logic        latch_b_irq_host_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// byte writes anywhere in the eight start time lanes
	wire start_wr_w = net_wr_i && net_addr_i[11:3] == 9'h132;
	wire lat_a_w    = net_addr_i == 12'h9a8 && host_addr_i == 12'h9a8;

	property p_irq; latch_a_irq_host_o == latch_a_own_host_i; endproperty
	a_irq: assert property (p_irq) else $error("latch irq route wrong");
	property p_irq_b; latch_b_irq_host_o == latch_b_own_host_i; endproperty
	a_irq_b: assert property (p_irq_b) else $error("latch b irq route wrong");
	property p_auto; start_wr_w && act_auto_i && !sync_own_host_i |-> act_auto_set_o; endproperty
	a_auto: assert property (p_auto) else $error("no auto activation");
	property p_own; sync_own_host_i |-> !act_auto_set_o; endproperty
	a_own: assert property (p_own) else $error("start taken under host");
	property p_lat_net;
		net_wr_i && !host_wr_i && net_addr_i == 12'h9a8 && !latch_a_own_host_i
		|=> {6'h0, latch_a_mode_o} == ($past(net_wdata_i) & 8'h03);
	endproperty
	a_lat_net: assert property (p_lat_net) else $error("latch a mode wrong");
	property p_lat_ref;
		host_wr_i && !net_wr_i && lat_a_w && !latch_a_own_host_i |=> $stable(latch_a_mode_o);
	endproperty
	a_lat_ref: assert property (p_lat_ref) else $error("latch a foreign write");
	property p_lat_b;
		host_wr_i && !net_wr_i && host_addr_i == 12'h9a9 && latch_b_own_host_i
		|=> {6'h0, latch_b_mode_o} == ($past(host_wdata_i) & 8'h03);
	endproperty
	a_lat_b: assert property (p_lat_b) else $error("latch b mode wrong");
	property p_hold;
		pulse_len_i == 16'h0 && sync_out_a_o && !(host_rd_i && host_addr_i == 12'h98e)
		|=> sync_out_a_o;
	endproperty
	a_hold: assert property (p_hold) else $error("ack output dropped");
	property p_rst;
		$rose(reset_n_i) |-> !sync_out_a_o && !sync_out_b_o && (latch_a_mode_o | latch_b_mode_o) == 2'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not clear");
endmodule

bind dcsl_regs dcsl_regs_props u_props (.ref_clk_i, .reset_n_i, .net_addr_i, .net_wr_i,
	.net_wdata_i, .host_addr_i, .host_wr_i, .host_rd_i, .host_wdata_i, .sync_own_host_i,
	.latch_a_own_host_i, .latch_b_own_host_i, .act_auto_i, .pulse_len_i, .act_auto_set_o,
	.sync_out_a_o, .sync_out_b_o, .latch_a_mode_o, .latch_b_mode_o, .latch_a_irq_host_o,
	.latch_b_irq_host_o);

// File: verification/dcsl_regs_tb.sv
// self-checking bench for the sync pulse and latch control registers
// assumes the time source model; reads answer one cycle after the strobe
module dcsl_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// nonzero upper word so upper-half extension is visible
	localparam logic [63:0] T0 = 64'h0000_0001_0000_0000;
	logic        ref_clk_i = 0, reset_n_i = 0, net_wr_i = 0, net_rd_i = 0, host_wr_i = 0;
	logic        host_rd_i = 0, net_frame_end_i = 0, sync_own_host_i = 0, act_near_long_i = 0;
	logic        latch_a_own_host_i = 0, latch_b_own_host_i = 0, act_enable_i = 0, act_auto_i = 0;
	logic        act_plaus_en_i = 0, act_gen_a_i = 0, act_gen_b_i = 0, nf = 0, hf = 0;
	logic [11:0] net_addr_i = 12'h0, host_addr_i = 12'h0;
	logic [7:0]  net_wdata_i = 8'h0, host_wdata_i = 8'h0, net_rdata_o, host_rdata_o, nq[$], hq[$];
	logic [15:0] pulse_len_i = 16'h0;
	logic [63:0] sys_time_i;
	logic [1:0]  latch_a_mode_o, latch_b_mode_o;
	logic        act_auto_set_o, sync_out_a_o, sync_out_b_o, latch_a_irq_host_o, latch_b_irq_host_o;
	int          miscompares = 0, num_checks = 0;

	dcsl_time_src #(.BASE(T0)) u_time (.ref_clk_i, .reset_n_i, .sys_time_o(sys_time_i));
	dcsl_regs u_dut (.ref_clk_i, .reset_n_i, .net_addr_i, .net_wr_i, .net_rd_i, .net_wdata_i,
		.net_frame_end_i, .net_rdata_o, .host_addr_i, .host_wr_i, .host_rd_i, .host_wdata_i,
		.host_rdata_o, .sync_own_host_i, .latch_a_own_host_i, .latch_b_own_host_i, .act_enable_i,
		.act_auto_i, .act_plaus_en_i, .act_near_long_i, .act_gen_a_i, .act_gen_b_i, .pulse_len_i,
		.sys_time_i, .act_auto_set_o, .sync_out_a_o, .sync_out_b_o, .latch_a_mode_o,
		.latch_b_mode_o, .latch_a_irq_host_o, .latch_b_irq_host_o);

	always #2.5 ref_clk_i = ~ref_clk_i;

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one byte access; a read notes its expected byte for the monitor
	task automatic acc(input bit h, input bit w, input logic [11:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		{host_wr_i, host_rd_i, net_wr_i, net_rd_i} = h ? {w, !w, 2'b00} : {2'b00, w, !w};
		{host_addr_i, net_addr_i, host_wdata_i, net_wdata_i} = {a, a, d, d};
		if (!w && h)
			hq.push_back(d);
		if (!w && !h)
			nq.push_back(d);
	endtask

	task automatic idle();
		@(negedge ref_clk_i);
		{host_wr_i, host_rd_i, net_wr_i, net_rd_i} = 4'h0;
	endtask

	task automatic xfer(input bit h, input bit w, input logic [11:0] a, input int n,
		input logic [63:0] v);
		for (int i = 0; i < n; i++)
			acc(h, w, a + 12'(i), v[8*i +: 8]);
		idle();
	endtask

	task automatic wait_out(input bit b);
		int n;
		n = 0;
		while ((b ? sync_out_b_o : sync_out_a_o) !== 1'b1 && n < 300)
		begin
			@(negedge ref_clk_i);
			n++;
		end
		check({7'h0, n < 300}, 8'h01);
	endtask

	always @(posedge ref_clk_i)
	begin
		nf <= net_rd_i;
		hf <= host_rd_i;
	end

	always @(negedge ref_clk_i)
	begin
		if (nf)
			check(net_rdata_o, nq.pop_front());
		if (hf)
			check(host_rdata_o, hq.pop_front());
	end

	initial
	begin
		#100000;
		miscompares++;
		complete_run();
	end

	initial
	begin
		logic [63:0] st;
		logic [31:0] r;
		logic [7:0]  d0, d1;
		void'($urandom(3888));
		repeat (12) @(negedge ref_clk_i);
		reset_n_i = 1'b1;
		for (int a = 'h984; a < 'h9ab; a++)
			acc(0, 0, 12'(a), 8'h0);
		idle();
		$display("reset values done");
		r = $urandom;
		xfer(0, 1, 12'h9a0, 4, 64'(r));
		xfer(1, 0, 12'h9a0, 4, 64'(r));
		{sync_own_host_i, act_auto_i} = 2'b11;
		xfer(0, 1, 12'h9a4, 4, 64'(~r));
		xfer(1, 1, 12'h9a4, 4, 64'(r ^ 32'h5a5a));
		xfer(0, 0, 12'h9a4, 4, 64'(r ^ 32'h5a5a));
		xfer(0, 1, 12'h990, 8, 64'h1);
		xfer(1, 1, 12'h990, 8, 64'h1);
		xfer(0, 0, 12'h990, 8, 64'h0);
		{sync_own_host_i, act_auto_i} = 2'b01;
		xfer(0, 1, 12'h990, 8, 64'h5_1234_5678);
		@(negedge ref_clk_i) net_frame_end_i = 1'b1;
		@(negedge ref_clk_i) net_frame_end_i = 1'b0;
		xfer(0, 0, 12'h990, 8, 64'h5_1234_5678);
		xfer(0, 1, 12'h990, 4, 64'h9abc_def0);
		@(negedge ref_clk_i) net_frame_end_i = 1'b1;
		@(negedge ref_clk_i) net_frame_end_i = 1'b0;
		xfer(1, 0, 12'h990, 8, {T0[63:32], 32'h9abc_def0});
		$display("ownership and start time done");
		for (int u = 0; u < 4; u++)
		begin
			{latch_a_own_host_i, latch_b_own_host_i} = {2{u[0]}};
			d0 = 8'($urandom);
			d1 = 8'($urandom);
			acc(0, 1, 12'h9a8 + 12'(u[1]), d0);
			acc(1, 1, 12'h9a8 + 12'(u[1]), d1);
			xfer(0, 0, 12'h9a8 + 12'(u[1]), 1, 64'((u[0] ? d1 : d0) & 8'h03));
			check({6'h0, u[1] ? latch_b_mode_o : latch_a_mode_o}, (u[0] ? d1 : d0) & 8'h03);
		end
		$display("latch control done");
		xfer(0, 1, 12'h9a0, 4, 64'h3e8);
		xfer(0, 1, 12'h9a4, 4, 64'h64);
		st = sys_time_i + 64'h190;
		xfer(0, 1, 12'h990, 8, st);
		{act_gen_a_i, act_gen_b_i, act_enable_i} = 3'h7;
		xfer(1, 0, 12'h984, 1, 64'h3);
		wait_out(0);
		xfer(1, 0, 12'h998, 8, st + 64'h64);
		xfer(1, 0, 12'h98e, 1, 64'h1);
		@(negedge ref_clk_i);
		check({7'h0, sync_out_a_o}, 8'h0);
		wait_out(1);
		xfer(1, 0, 12'h984, 1, 64'h0);
		xfer(1, 0, 12'h98f, 1, 64'h1);
		@(negedge ref_clk_i);
		check({7'h0, sync_out_b_o}, 8'h0);
		xfer(0, 0, 12'h990, 8, st + 64'h3e8);
		$display("sync outputs done");
		{act_enable_i, act_gen_b_i, act_plaus_en_i, pulse_len_i} = {3'h1, 16'h1};
		// between the two window sizes, so only the short window flags it
		st = sys_time_i + 64'hc000_0000;
		xfer(0, 1, 12'h990, 8, st);
		for (int k = 0; k < 2; k++)
		begin
			act_near_long_i = k[0];
			act_enable_i = 1'b1;
			repeat (8) @(negedge ref_clk_i);
			xfer(1, 0, 12'h984, 1, k[0] ? 64'h4 : 64'h1);
			act_enable_i = 1'b0;
			@(negedge ref_clk_i);
		end
		xfer(1, 0, 12'h990, 8, st + 64'h3e8);
		$display("plausibility done");
		complete_run();
	end
endmodule

// File: verification/dcsl_time_src.sv
// system time source in ns standing in for the local clock unit
// assumes ref_clk_i at 200 MHz, so time advances 5 ns a cycle
module dcsl_time_src #(
	parameter logic [63:0] BASE = 64'h0
) (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_n_i,
	// time
	output logic      [63:0] sys_time_o
);
	timeunit 1ns;
	timeprecision 100ps;
	always_ff @(posedge ref_clk_i)
		sys_time_o <= reset_n_i ? sys_time_o + 64'h5 : BASE;
endmodule
